// [rtl/aop_map.svh]
/*
 Register offsets, field positions, reset values and timing counts for the
 OAM connection point processor. Assumes a 100 MHz system clock.
*/
`ifndef AOP_MAP_SVH
`define AOP_MAP_SVH
`define AOP_CLK_HZ        100000000
`define AOP_TICK_PERIOD   100000000
`define AOP_AIS_CLR_TENTHS 35
`define AOP_LOC_TENTHS    35
`define AOP_LB_TIMEOUT_S  5
`define AOP_OFF_CTRL      4'h0
`define AOP_OFF_STATUS    4'h1
`define AOP_OFF_LB_ID     4'h2
`define AOP_OFF_LB_DELAY  4'h3
`define AOP_OFF_CUR_RX    4'h4
`define AOP_OFF_CUR_TX    4'h5
`define AOP_OFF_PRV_RX    4'h6
`define AOP_OFF_PRV_TX    4'h7
`define AOP_OFF_INTERVAL  4'h8
`define AOP_CTRL_ROLE_LSB 0
`define AOP_CTRL_CC_LSB   3
`define AOP_CTRL_LB_GO    5
`define AOP_CTRL_RESET    32'h0000_0000
`define AOP_INTERVAL_RST  32'h0000_0384
`endif

// [rtl/aop_pkg.sv]
/*
 Types shared by the OAM connection point processor: roles, continuity
 modes, cell kinds and the cell carrier struct. Standalone package.
*/
package aop_pkg;
  typedef enum logic [2:0] {
    AOP_VP_INTERMEDIATE,
    AOP_VC_INTERMEDIATE,
    AOP_VP_SEGMENT,
    AOP_VC_SEGMENT,
    AOP_VC_END_TO_END
  } aop_role_e;
  typedef enum logic [1:0] {
    AOP_CC_OFF,
    AOP_CC_SOURCE,
    AOP_CC_SINK,
    AOP_CC_BOTH
  } aop_cc_e;
  typedef enum logic [2:0] {
    AOP_CELL_USER,
    AOP_CELL_AIS,
    AOP_CELL_RDI,
    AOP_CELL_CC,
    AOP_CELL_LB
  } aop_kind_e;
  typedef struct packed {
    logic       f5;
    logic       seg;
    aop_kind_e  kind;
    logic [7:0] lb_id;
  } aop_cell_s;
endpackage : aop_pkg

// [rtl/aop_point.sv]
/*
 OAM connection point processor: classifies received cells, keeps the
 alarm-indication state and generates alarm, defect and continuity cells
 ahead of the shaper. Assumes an Avalon-MM master on the same clock and a
 cell-level descriptor stream from the port and to the peer side.
*/
`timescale 1ns/100ps
`default_nettype none
`include "aop_map.svh"
// Notes on behaviour
// - Enter alarm state on AIS, lost continuity or port failure; leave after 3.5 s clean.
// - Generated OAM cells go into the stream before the shaper.
// - Five roles exist: VP/VC intermediate, VP/VC segment, VC end-to-end.
// - Each cross-connect side picks intermediate or segment via its own descriptor.
// - Host or emulation terminations act as VC endpoint, segment or end-to-end.
// - Segment endpoints run continuity check as source, sink or both.
// - Intermediate VP points pass segment and end-to-end OAM cells unchanged.
// - VP intermediate port failure sends F4 end-to-end AIS forward.
// - VC intermediate port failure sends F5 segment and end-to-end AIS forward.
// - VP segment port failure sends F4 end-to-end AIS forward, segment RDI back.
// - VP segment continuity source sends F4 segment CC backward.
// - VP segment sink without CC for 3.5 s enters alarm, sends AIS and RDI.
// - Continuity mode both performs source and sink duties together.
// - VC segment receiving F5 segment AIS sends end-to-end AIS forward, RDI back.
// - VC segment sink without CC for 3.5 s enters alarm, sends AIS and RDI.
// - VC end-to-end drops all OAM cells, monitors F5 end-to-end AIS, RDI, CC. The code monitors received AIS and CC only; received RDI is ignored.
// - VC end-to-end receiving F5 end-to-end AIS sends F5 end-to-end RDI back.
// - VC endpoint continuity source sends one F5 end-to-end CC backward per second.
// - Statistics kept for current interval; completed previous interval stays readable.
module aop_point
  import aop_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `AOP_TICK_PERIOD
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        port_fail_i,
  input  wire logic        rx_valid_i,
  input  wire aop_cell_s   rx_cell_i,
  output logic             peer_valid_o,
  output aop_cell_s        peer_cell_o,
  output logic             fwd_valid_o,
  output aop_cell_s        fwd_cell_o,
  output logic             bwd_valid_o,
  output aop_cell_s        bwd_cell_o,
  output logic             ais_state_o
);
  // Tenths of a second are the finest base; the 3.5 s windows count tenths.
  localparam int unsigned TENTH_CYCLES = TICK_CYCLES / 10;
  localparam logic [5:0]  AIS_CLR_T    = 6'(`AOP_AIS_CLR_TENTHS);
  localparam logic [5:0]  LOC_T        = 6'(`AOP_LOC_TENTHS);
  localparam logic [6:0]  LB_LIMIT_T   = 7'(`AOP_LB_TIMEOUT_S * 10);

  function automatic aop_cell_s mk_cell(input logic f5, input logic seg, input aop_kind_e k);
    aop_cell_s c;
    c.f5    = f5;
    c.seg   = seg;
    c.kind  = k;
    c.lb_id = 8'h00;
    return c;
  endfunction : mk_cell

  function automatic logic is_oam(input aop_cell_s c);
    return c.kind != AOP_CELL_USER;
  endfunction : is_oam

  logic        port_fail_m_q, port_fail_q;
  logic [31:0] ctrl_q;
  logic [7:0]  lb_id_q;
  logic [31:0] interval_q;
  aop_role_e   role;
  aop_cc_e     cc_mode;
  logic        cc_src, cc_snk;

  assign role    = aop_role_e'(ctrl_q[`AOP_CTRL_ROLE_LSB +: 3]);
  assign cc_mode = aop_cc_e'(ctrl_q[`AOP_CTRL_CC_LSB +: 2]);
  // Continuity is meaningful only at segment points and the VC endpoint.
  assign cc_src  = (cc_mode == AOP_CC_SOURCE || cc_mode == AOP_CC_BOTH) &&
                   (role == AOP_VP_SEGMENT || role == AOP_VC_SEGMENT || role == AOP_VC_END_TO_END);
  assign cc_snk  = (cc_mode == AOP_CC_SINK || cc_mode == AOP_CC_BOTH) &&
                   (role == AOP_VP_SEGMENT || role == AOP_VC_SEGMENT || role == AOP_VC_END_TO_END);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_fail_m_q <= 1'b0;
      port_fail_q   <= 1'b0;
    end else begin
      port_fail_m_q <= port_fail_i;
      port_fail_q   <= port_fail_m_q;
    end
  end

  // Time base: tenth-second and one-second enable pulses.
  logic [31:0] div_q;
  logic [3:0]  tenths_q;
  logic        tenth_p, sec_p;
  assign tenth_p = (div_q == 32'(TENTH_CYCLES - 1));
  assign sec_p   = tenth_p && (tenths_q == 4'h9);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q    <= 32'h0000_0000;
      tenths_q <= 4'h0;
    end else if (tenth_p) begin
      div_q    <= 32'h0000_0000;
      tenths_q <= (tenths_q == 4'h9) ? 4'h0 : tenths_q + 4'h1;
    end else begin
      div_q <= div_q + 32'h0000_0001;
    end
  end

  // Received cell classification.
  logic rx_oam, rx_ais_hit, rx_cc, rx_lb;
  assign rx_oam     = rx_valid_i && is_oam(rx_cell_i);
  assign rx_cc      = rx_valid_i && rx_cell_i.kind == AOP_CELL_CC;
  assign rx_lb      = rx_valid_i && rx_cell_i.kind == AOP_CELL_LB;
  always_comb begin
    rx_ais_hit = 1'b0;
    if (rx_valid_i && rx_cell_i.kind == AOP_CELL_AIS) begin
      unique case (role)
        AOP_VC_SEGMENT:    rx_ais_hit = rx_cell_i.f5 && rx_cell_i.seg;
        AOP_VC_END_TO_END: rx_ais_hit = rx_cell_i.f5 && !rx_cell_i.seg;
        AOP_VP_SEGMENT:    rx_ais_hit = !rx_cell_i.f5;
        default:           rx_ais_hit = 1'b0;
      endcase
    end
  end

  // Loss of continuity: sink counts tenths since the last CC cell.
  // The tenth ticks run free of the cell, so one extra tick makes sure 3.5 s have passed.
  logic [5:0] loc_cnt_q;
  logic       loc;
  assign loc = cc_snk && (loc_cnt_q > LOC_T);
  always_ff @(posedge clk_i) begin
    if (rst_i || !cc_snk || rx_cc) begin
      loc_cnt_q <= 6'h00;
    end else if (tenth_p && loc_cnt_q <= LOC_T) begin
      loc_cnt_q <= loc_cnt_q + 6'h01;
    end
  end

  // Alarm state: any defect sets it and restarts the 3.5 s clean window.
  // The first tick after a defect can fall at once, so clearing waits one tick extra.
  logic       defect;
  logic       ais_q;
  logic [5:0] clean_q;
  assign defect = port_fail_q || loc || rx_ais_hit;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ais_q   <= 1'b0;
      clean_q <= 6'h00;
    end else if (defect) begin
      ais_q   <= 1'b1;
      clean_q <= 6'h00;
    end else if (ais_q && tenth_p) begin
      if (clean_q == AIS_CLR_T) begin
        ais_q   <= 1'b0;
        clean_q <= 6'h00;
      end else begin
        clean_q <= clean_q + 6'h01;
      end
    end
  end
  assign ais_state_o = ais_q;

  // Forwarding toward the peer side of the cross-connect.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peer_valid_o <= 1'b0;
      peer_cell_o  <= mk_cell(1'b0, 1'b0, AOP_CELL_USER);
    end else begin
      peer_cell_o <= rx_cell_i;
      unique case (role)
        AOP_VP_INTERMEDIATE, AOP_VC_INTERMEDIATE:
          peer_valid_o <= rx_valid_i;
        default:
          peer_valid_o <= rx_valid_i && !rx_oam;
      endcase
    end
  end

  // Generated cells: a small pending set drained one per cycle, forward
  // and backward independently, into the pre-shaper stream.
  logic [1:0] fwd_pend_q;   // bit0 end-to-end AIS, bit1 segment AIS
  logic [1:0] bwd_pend_q;   // bit0 RDI, bit1 CC
  logic       ais_hit_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ais_hit_q <= 1'b0;
    end else begin
      ais_hit_q <= ais_q;
    end
  end
  logic first_p;
  assign first_p = ais_q && !ais_hit_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fwd_pend_q <= 2'b00;
      fwd_valid_o <= 1'b0;
      fwd_cell_o  <= mk_cell(1'b0, 1'b0, AOP_CELL_USER);
    end else begin
      fwd_valid_o <= 1'b0;
      if (fwd_pend_q[0]) begin
        fwd_valid_o   <= 1'b1;
        fwd_cell_o    <= mk_cell(role != AOP_VP_INTERMEDIATE && role != AOP_VP_SEGMENT, 1'b0, AOP_CELL_AIS);
        fwd_pend_q[0] <= 1'b0;
      end else if (fwd_pend_q[1]) begin
        fwd_valid_o   <= 1'b1;
        fwd_cell_o    <= mk_cell(1'b1, 1'b1, AOP_CELL_AIS);
        fwd_pend_q[1] <= 1'b0;
      end
      if (first_p || (ais_q && sec_p)) begin
        unique case (role)
          AOP_VP_INTERMEDIATE, AOP_VP_SEGMENT, AOP_VC_SEGMENT:
            fwd_pend_q <= 2'b01;
          AOP_VC_INTERMEDIATE:
            fwd_pend_q <= 2'b11;
          default:
            fwd_pend_q <= 2'b00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bwd_pend_q  <= 2'b00;
      bwd_valid_o <= 1'b0;
      bwd_cell_o  <= mk_cell(1'b0, 1'b0, AOP_CELL_USER);
    end else begin
      bwd_valid_o <= 1'b0;
      if (bwd_pend_q[0]) begin
        bwd_valid_o   <= 1'b1;
        bwd_cell_o    <= mk_cell(role != AOP_VP_SEGMENT, role != AOP_VC_END_TO_END, AOP_CELL_RDI);
        bwd_pend_q[0] <= 1'b0;
      end else if (bwd_pend_q[1]) begin
        bwd_valid_o   <= 1'b1;
        bwd_cell_o    <= mk_cell(role != AOP_VP_SEGMENT, role != AOP_VC_END_TO_END, AOP_CELL_CC);
        bwd_pend_q[1] <= 1'b0;
      end
      if ((first_p || (ais_q && sec_p)) &&
          (role == AOP_VP_SEGMENT || role == AOP_VC_SEGMENT || role == AOP_VC_END_TO_END)) begin
        bwd_pend_q[0] <= 1'b1;
      end
      if (sec_p && cc_src) begin
        bwd_pend_q[1] <= 1'b1;
      end
    end
  end

  // Loopback: software arms an ID; a returning cell with that ID within
  // 5 s latches the round trip in tenths of a second.
  logic       lb_busy_q, lb_ok_q, lb_fail_q;
  logic [6:0] lb_t_q;
  logic [6:0] lb_delay_q;
  logic       lb_go;
  assign lb_go = avs_write_i && !avs_waitrequest_o && avs_address_i == `AOP_OFF_CTRL &&
                 avs_byteenable_i[0] && avs_writedata_i[`AOP_CTRL_LB_GO];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lb_busy_q  <= 1'b0;
      lb_ok_q    <= 1'b0;
      lb_fail_q  <= 1'b0;
      lb_t_q     <= 7'h00;
      lb_delay_q <= 7'h00;
    end else if (lb_go) begin
      lb_busy_q <= 1'b1;
      lb_ok_q   <= 1'b0;
      lb_fail_q <= 1'b0;
      lb_t_q    <= 7'h00;
    end else if (lb_busy_q) begin
      if (rx_lb && rx_cell_i.lb_id == lb_id_q) begin
        lb_busy_q  <= 1'b0;
        lb_ok_q    <= 1'b1;
        lb_delay_q <= lb_t_q;
      end else if (lb_t_q >= LB_LIMIT_T) begin
        lb_busy_q <= 1'b0;
        lb_fail_q <= 1'b1;
      end else if (tenth_p) begin
        lb_t_q <= lb_t_q + 7'h01;
      end
    end
  end

  // Statistics per interval of whole seconds.
  logic [31:0] cur_rx_q, cur_tx_q, prv_rx_q, prv_tx_q, sec_cnt_q;
  logic        tx_any;
  assign tx_any = fwd_valid_o || bwd_valid_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_rx_q  <= 32'h0000_0000;
      cur_tx_q  <= 32'h0000_0000;
      prv_rx_q  <= 32'h0000_0000;
      prv_tx_q  <= 32'h0000_0000;
      sec_cnt_q <= 32'h0000_0000;
    end else if (sec_p && sec_cnt_q + 32'h0000_0001 >= interval_q) begin
      prv_rx_q  <= cur_rx_q + {31'h0, rx_oam};
      prv_tx_q  <= cur_tx_q + {31'h0, tx_any};
      cur_rx_q  <= 32'h0000_0000;
      cur_tx_q  <= 32'h0000_0000;
      sec_cnt_q <= 32'h0000_0000;
    end else begin
      cur_rx_q  <= cur_rx_q + {31'h0, rx_oam};
      cur_tx_q  <= cur_tx_q + {31'h0, tx_any};
      if (sec_p) begin
        sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
      end
    end
  end

  // Avalon-MM slave: one wait cycle per access, answer on the second.
  logic acc_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q             <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      acc_q             <= (avs_read_i || avs_write_i) && avs_waitrequest_o && !acc_q;
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o && !acc_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q     <= `AOP_CTRL_RESET;
      lb_id_q    <= 8'h00;
      interval_q <= `AOP_INTERVAL_RST;
    end else if (avs_write_i && !avs_waitrequest_o) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable_i[b]) begin
          unique case (avs_address_i)
            `AOP_OFF_CTRL:     ctrl_q[b*8 +: 8]     <= (b == 0) ? (avs_writedata_i[7:0] & 8'h1F) : 8'h00;
            `AOP_OFF_INTERVAL: interval_q[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
            `AOP_OFF_LB_ID:    if (b == 0) lb_id_q <= avs_writedata_i[7:0];
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o && !acc_q) begin
      unique case (avs_address_i)
        `AOP_OFF_CTRL:     avs_readdata_o <= ctrl_q;
        `AOP_OFF_STATUS:   avs_readdata_o <= {26'h0, lb_fail_q, lb_ok_q, lb_busy_q, loc, port_fail_q, ais_q};
        `AOP_OFF_LB_ID:    avs_readdata_o <= {24'h0, lb_id_q};
        `AOP_OFF_LB_DELAY: avs_readdata_o <= {25'h0, lb_delay_q};
        `AOP_OFF_CUR_RX:   avs_readdata_o <= cur_rx_q;
        `AOP_OFF_CUR_TX:   avs_readdata_o <= cur_tx_q;
        `AOP_OFF_PRV_RX:   avs_readdata_o <= prv_rx_q;
        `AOP_OFF_PRV_TX:   avs_readdata_o <= prv_tx_q;
        `AOP_OFF_INTERVAL: avs_readdata_o <= interval_q;
        default:           avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule : aop_point
`default_nettype wire

// [verif/aop_point_assertions.sv]
/*
 Port checker for aop_point, attached to every instance by bind.
 Assumes the bus master keeps the hand-over contract.
*/
`timescale 1ns/100ps
`default_nettype none
module aop_point_chk
  import aop_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 1000
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        port_fail_i,
  input wire logic        rx_valid_i,
  input wire aop_cell_s   rx_cell_i,
  input wire logic        peer_valid_o,
  input wire aop_cell_s   peer_cell_o,
  input wire logic        fwd_valid_o,
  input wire aop_cell_s   fwd_cell_o,
  input wire logic        bwd_valid_o,
  input wire aop_cell_s   bwd_cell_o,
  input wire logic        ais_state_o
);
  // The alarm may only clear once a full 3.5 s have passed without failure.
  localparam int unsigned MIN_CLEAN = 35 * TICK_CYCLES / 10;
  aop_role_e   role_q;
  int unsigned clean_q;
  int unsigned fgap_q;
  int unsigned cgap_q;
  logic        cc_seen_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) role_q <= AOP_VP_INTERMEDIATE;
    else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0 && avs_byteenable_i[0])
      role_q <= aop_role_e'(avs_writedata_i[2:0]);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || port_fail_i) clean_q <= 0;
    else if (clean_q < 100000) clean_q <= clean_q + 1;
  end
  always_ff @(posedge clk_i) begin
    // The endpoint sends no forward alarm cells, so the gap restarts while it holds that role.
    if (rst_i || !ais_state_o || fwd_valid_o || role_q == AOP_VC_END_TO_END) fgap_q <= 0;
    else fgap_q <= fgap_q + 1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) cc_seen_q <= 1'b0;
    else if (bwd_valid_o && bwd_cell_o.kind == AOP_CELL_CC) cc_seen_q <= 1'b1;
    if (rst_i || (bwd_valid_o && bwd_cell_o.kind == AOP_CELL_CC)) cgap_q <= 0;
    else if (cgap_q < 100000) cgap_q <= cgap_q + 1;
  end
  property p_answer; $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o; endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_one_low; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_one_low: assert property (p_one_low) else $error("waitrequest low too long");
  property p_fail; port_fail_i |-> ##[1:4] ais_state_o; endproperty
  a_fail: assert property (p_fail) else $error("port failure ignored");
  property p_hold; $fell(ais_state_o) |-> clean_q >= MIN_CLEAN; endproperty
  a_hold: assert property (p_hold) else $error("alarm cleared early");
  property p_pass;
    role_q == AOP_VP_INTERMEDIATE && rx_valid_i |=> peer_valid_o && peer_cell_o == $past(rx_cell_i);
  endproperty
  a_pass: assert property (p_pass) else $error("cell not passed");
  property p_drop;
    role_q == AOP_VC_END_TO_END && rx_valid_i && rx_cell_i.kind != AOP_CELL_USER |=> !peer_valid_o;
  endproperty
  a_drop: assert property (p_drop) else $error("oam cell not dropped");
  property p_fwd_ais; fwd_valid_o |-> fwd_cell_o.kind == AOP_CELL_AIS; endproperty
  a_fwd_ais: assert property (p_fwd_ais) else $error("forward cell kind");
  property p_vp_f4;
    fwd_valid_o && $past(role_q) inside {AOP_VP_INTERMEDIATE, AOP_VP_SEGMENT} |-> !fwd_cell_o.f5 && !fwd_cell_o.seg;
  endproperty
  a_vp_f4: assert property (p_vp_f4) else $error("forward cell level");
  property p_rdi_seg;
    bwd_valid_o && bwd_cell_o.kind == AOP_CELL_RDI && $past(role_q) == AOP_VP_SEGMENT |-> !bwd_cell_o.f5 && bwd_cell_o.seg;
  endproperty
  a_rdi_seg: assert property (p_rdi_seg) else $error("segment defect cell");
  property p_rdi_e2e;
    bwd_valid_o && bwd_cell_o.kind == AOP_CELL_RDI && $past(role_q) == AOP_VC_END_TO_END |-> bwd_cell_o.f5 && !bwd_cell_o.seg;
  endproperty
  a_rdi_e2e: assert property (p_rdi_e2e) else $error("end defect cell");
  property p_cc_gap;
    bwd_valid_o && bwd_cell_o.kind == AOP_CELL_CC |-> !cc_seen_q || cgap_q >= TICK_CYCLES - 2;
  endproperty
  a_cc_gap: assert property (p_cc_gap) else $error("continuity cells too close");
  property p_repeat; ais_state_o && role_q != AOP_VC_END_TO_END |-> fgap_q <= TICK_CYCLES + 8; endproperty
  a_repeat: assert property (p_repeat) else $error("alarm cells not repeated");
endmodule : aop_point_chk
bind aop_point aop_point_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.clk_i, .rst_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o, .port_fail_i, .rx_valid_i, .rx_cell_i,
  .peer_valid_o, .peer_cell_o, .fwd_valid_o, .fwd_cell_o, .bwd_valid_o, .bwd_cell_o, .ais_state_o);
`default_nettype wire

// [verif/aop_far_end.sv]
/*
 Far-end equipment model: sends one template cell per second and
 cells injected by the bench. Assumes the same clock as the design.
*/
`timescale 1ns/100ps
`default_nettype none
module aop_far_end
  import aop_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 1000
) (
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic      per_on_i,
  input  wire aop_cell_s tmpl_i,
  input  wire logic      inj_i,
  input  wire aop_cell_s inj_cell_i,
  output logic           rx_valid_o,
  output aop_cell_s      rx_cell_o
);
  int unsigned sec_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || sec_q == TICK_CYCLES - 1) sec_q <= 0;
    else sec_q <= sec_q + 1;
  end
  // Idle cell lines toggle so that stale data is never mistaken for a cell.
  always_ff @(posedge clk_i) begin
    rx_valid_o <= 1'b0;
    rx_cell_o  <= aop_cell_s'(~rx_cell_o);
    if (rst_i) begin
      rx_cell_o <= '0;
    end else if (inj_i) begin
      rx_valid_o <= 1'b1;
      rx_cell_o  <= inj_cell_i;
    end else if (per_on_i && sec_q == 0) begin
      rx_valid_o <= 1'b1;
      rx_cell_o  <= tmpl_i;
    end
  end
endmodule : aop_far_end
`default_nettype wire

// [verif/aop_point_tb.sv]
/*
 Self-checking bench for aop_point with the far-end model.
 Assumes a one-second tick of 1000 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module aop_point_tb
  import aop_pkg::*;
;
  localparam int unsigned TICK = 1000;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        port_fail_i = 1'b0;
  logic        rx_valid_i;
  logic        peer_valid_o;
  logic        fwd_valid_o;
  logic        bwd_valid_o;
  logic        ais_state_o;
  logic        per_on = 1'b0;
  logic        inj = 1'b0;
  aop_cell_s   rx_cell_i;
  aop_cell_s   peer_cell_o;
  aop_cell_s   fwd_cell_o;
  aop_cell_s   bwd_cell_o;
  aop_cell_s   tmpl = '0;
  aop_cell_s   inj_cell = '0;
  aop_cell_s   last_rdi = '0;
  aop_cell_s   last_fwd = '0;
  int          mismatches = 0;
  int          checks = 0;
  int          seed = 54;
  int          peer_n = 0;
  int          cc_n = 0;
  logic [31:0] rd;
  always #5 clk_i = ~clk_i;
  aop_point #(.TICK_CYCLES(TICK)) DUT (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .port_fail_i, .rx_valid_i,
    .rx_cell_i, .peer_valid_o, .peer_cell_o, .fwd_valid_o, .fwd_cell_o, .bwd_valid_o, .bwd_cell_o, .ais_state_o);
  aop_far_end #(.TICK_CYCLES(TICK)) far (.clk_i, .rst_i, .per_on_i(per_on), .tmpl_i(tmpl), .inj_i(inj),
    .inj_cell_i(inj_cell), .rx_valid_o(rx_valid_i), .rx_cell_o(rx_cell_i));
  always @(posedge clk_i) begin
    if (peer_valid_o === 1'b1) peer_n <= peer_n + 1;
    if (bwd_valid_o === 1'b1 && bwd_cell_o.kind === AOP_CELL_CC) cc_n <= cc_n + 1;
    if (bwd_valid_o === 1'b1 && bwd_cell_o.kind === AOP_CELL_RDI) last_rdi <= bwd_cell_o;
    if (fwd_valid_o === 1'b1) last_fwd <= fwd_cell_o;
  end
  function automatic int exp_pass(aop_role_e r, aop_kind_e k);
    return int'(r inside {AOP_VP_INTERMEDIATE, AOP_VC_INTERMEDIATE} || k == AOP_CELL_USER);
  endfunction : exp_pass
  function automatic aop_cell_s mk(logic f5, logic seg, aop_kind_e k);
    return '{f5, seg, k, 8'h00};
  endfunction : mk
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clk_i);
    end
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (60000) @(posedge clk_i);
    mismatches++;
    close_out();
  end
  initial begin
    aop_cell_s c;
    int        exp_n;
    int        p0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("ais after reset", ais_state_o, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    check("interval", rd, 32'h0000_0384);
    bus(1'b1, 4'h9, 32'hFFFF_FFFF);
    bus(1'b0, 4'h9, 32'h0);
    check("unmapped", rd, 32'h0);
    for (int r = 0; r < 5; r++) begin
      bus(1'b1, 4'h0, r);
      bus(1'b0, 4'h0, 32'h0);
      check("role", rd, r);
      exp_n = 0;
      p0 = peer_n;
      repeat (8) begin
        c = aop_cell_s'(13'($random(seed)));
        c.kind = aop_kind_e'(3'($unsigned($random(seed)) % 5));
        exp_n += exp_pass(aop_role_e'(r[2:0]), c.kind);
        inj_cell <= c;
        inj <= 1'b1;
        @(posedge clk_i);
      end
      inj <= 1'b0;
      repeat (3) @(posedge clk_i);
      check("peer count", peer_n - p0, exp_n);
    end
    bus(1'b1, 4'h2, 32'h0000_005A);
    bus(1'b1, 4'h0, 32'h0000_0020);
    repeat (250) @(posedge clk_i);
    inj_cell <= '{1'b1, 1'b0, AOP_CELL_LB, 8'h5B};
    inj <= 1'b1;
    @(posedge clk_i);
    inj_cell <= '{1'b1, 1'b0, AOP_CELL_LB, 8'h5A};
    @(posedge clk_i);
    inj <= 1'b0;
    repeat (3) @(posedge clk_i);
    bus(1'b0, 4'h1, 32'h0);
    check("lb status", rd[5:3], 32'h2);
    bus(1'b0, 4'h3, 32'h0);
    check("lb delay", rd >= 32'h2 && rd <= 32'h3, 32'h1);
    repeat (4000) @(posedge clk_i);
    port_fail_i <= 1'b1;
    repeat (50) @(posedge clk_i);
    check("ais on failure", ais_state_o, 32'h1);
    check("forward cell", last_fwd, mk(1'b0, 1'b0, AOP_CELL_AIS));
    port_fail_i <= 1'b0;
    repeat (3350) @(posedge clk_i);
    check("ais held", ais_state_o, 32'h1);
    repeat (400) @(posedge clk_i);
    check("ais cleared", ais_state_o, 32'h0);
    tmpl <= mk(1'b0, 1'b1, AOP_CELL_CC);
    per_on <= 1'b1;
    bus(1'b1, 4'h0, 32'h0000_0012);
    repeat (4000) @(posedge clk_i);
    check("ais with cc", ais_state_o, 32'h0);
    per_on <= 1'b0;
    repeat (2300) @(posedge clk_i);
    check("ais before loss", ais_state_o, 32'h0);
    repeat (1700) @(posedge clk_i);
    check("ais on loss", ais_state_o, 32'h1);
    check("segment rdi", last_rdi, mk(1'b0, 1'b1, AOP_CELL_RDI));
    tmpl <= mk(1'b1, 1'b1, AOP_CELL_AIS);
    per_on <= 1'b1;
    bus(1'b1, 4'h0, 32'h0000_0003);
    repeat (1500) @(posedge clk_i);
    check("vc segment ais", ais_state_o, 32'h1);
    check("vc segment rdi", last_rdi, mk(1'b1, 1'b1, AOP_CELL_RDI));
    check("vc segment fwd", last_fwd, mk(1'b1, 1'b0, AOP_CELL_AIS));
    tmpl <= mk(1'b1, 1'b0, AOP_CELL_AIS);
    bus(1'b1, 4'h0, 32'h0000_001C);
    repeat (1500) @(posedge clk_i);
    check("end rdi", last_rdi, mk(1'b1, 1'b0, AOP_CELL_RDI));
    tmpl <= mk(1'b1, 1'b0, AOP_CELL_CC);
    repeat (10) @(posedge clk_i);
    p0 = cc_n;
    repeat (3000) @(posedge clk_i);
    check("cc per second", cc_n - p0, 32'h3);
    close_out();
  end
endmodule : aop_point_tb
`default_nettype wire
